// File: hdl/ttsc_change_tag.sv
// What this block does
// - Response byte 0 carries code 04h
// - Echo channel and toggle, upper bits reserved
// - Byte 2 status, byte 3 reply count
// - Configure head on addressed channel
// - Store tag type per channel non-volatile
// - Recognise listed tag type codes only
// - Code 99 defers to head default
// - Factory restore sets 99 on all channels
// - Type 33 uses eight-byte memory blocks
// - Types 40, 42, 43 accept 4/7-byte IDs
module ttsc_change_tag #(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Command frame in
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_b0,
    input wire logic [7:0] cmd_b1,
    input wire logic [7:0] cmd_b2,
    input wire logic [7:0] cmd_b3,
    // Factory default restore request
    input wire logic factory_restore,
    // Response frame out
    output logic rsp_valid,
    output logic [7:0] rsp_b0,
    output logic [7:0] rsp_b1,
    output logic [7:0] rsp_b2,
    output logic [7:0] rsp_b3,
    output logic [7:0] rsp_b4,
    output logic [7:0] rsp_b5,
    output logic [7:0] rsp_b6,
    output logic [7:0] rsp_b7,
    // Head configuration
    output logic head_cfg_valid,
    output logic [2:0] head_cfg_chan,
    output logic [7:0] head_cfg_type,
    output logic head_cfg_use_default,
    // Non-volatile store write
    output logic nv_wr,
    output logic [2:0] nv_chan,
    output logic [7:0] nv_type,
    // Per-channel memory geometry
    output logic [CHANNELS-1:0] chan_block8,
    output logic [CHANNELS-1:0] chan_uid_4or7
);

    logic [7:0] tag_r [CHANNELS];
    logic [7:0] reply_cnt_r;
    logic [7:0] code_nxt;
    logic code_ok;
    logic [2:0] chan;
    logic chan_ok;
    logic is_ct;

    assign chan = cmd_b1[3:1];
    assign chan_ok = 32'(chan) < CHANNELS;
    assign is_ct = cmd_b0 == ttsc_pkg::CMD_CHANGE_TAG;
    // Two ASCII digits packed into BCD
    assign code_nxt = {cmd_b2[3:0], cmd_b3[3:0]};

    // Accepted codes table
    always_comb begin
        code_ok = 1'b0;
        if (cmd_b2 >= ttsc_pkg::ASCII_ZERO && cmd_b2 <= ttsc_pkg::ASCII_NINE &&
            cmd_b3 >= ttsc_pkg::ASCII_ZERO && cmd_b3 <= ttsc_pkg::ASCII_NINE) begin
            case (code_nxt)
                // One code a line so a missing family stands out
                8'h02,
                8'h03,
                8'h11,
                8'h12,
                8'h20,
                8'h21,
                8'h22,
                8'h23,
                8'h24,
                8'h31,
                8'h33,
                8'h34,
                8'h35,
                8'h40,
                8'h41,
                8'h42,
                8'h43,
                8'h50,
                8'h52,
                8'h72,
                8'h73,
                8'h74,
                8'h75,
                8'h76,
                8'h80,
                8'h99: code_ok = 1'b1;
                default: code_ok = 1'b0;
            endcase
        end
    end

    logic accept;
    assign accept = cmd_valid && is_ct && chan_ok && code_ok;

    // Held types load accepted codes; reset and restore load 99 without writing the store
    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    tag_r[g] <= ttsc_pkg::TAG_DEFAULT_CODE;
                end else if (factory_restore) begin
                    tag_r[g] <= ttsc_pkg::TAG_DEFAULT_CODE;
                end else if (accept && 32'(chan) == g) begin
                    tag_r[g] <= code_nxt;
                end
            end
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    chan_block8[g] <= 1'b0;
                    chan_uid_4or7[g] <= 1'b0;
                end else begin
                    chan_block8[g] <= tag_r[g] == ttsc_pkg::TAG_BLOCK8_CODE;
                    chan_uid_4or7[g] <= tag_r[g] == 8'h40 || tag_r[g] == 8'h42 ||
                        tag_r[g] == 8'h43;
                end
            end

            // Per-channel checks; restore beats a same-cycle accept
            a_restore_chan: assert property (@(posedge clk_sys) disable iff (rst)
                factory_restore |=> tag_r[g] == ttsc_pkg::TAG_DEFAULT_CODE)
                else $error("channel not restored");
            a_geom_block8: assert property (@(posedge clk_sys) disable iff (rst)
                tag_r[g] == ttsc_pkg::TAG_BLOCK8_CODE |=> chan_block8[g])
                else $error("wide block flag missing");
            a_geom_uid: assert property (@(posedge clk_sys) disable iff (rst)
                tag_r[g] == 8'h42 |=> chan_uid_4or7[g])
                else $error("uid length flag missing");
            a_store_chan: assert property (@(posedge clk_sys) disable iff (rst)
                accept && !factory_restore && 32'(chan) == g |=> tag_r[g] == $past(code_nxt))
                else $error("held type not updated");
        end
    endgenerate

    // Response frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_b0 <= 8'h00;
            rsp_b1 <= 8'h00;
            rsp_b2 <= 8'h00;
            rsp_b3 <= 8'h00;
            reply_cnt_r <= ttsc_pkg::RESET_REPLY_COUNT;
        end else begin
            rsp_valid <= cmd_valid;
            if (cmd_valid) begin
                rsp_b0 <= ttsc_pkg::CMD_CHANGE_TAG;
                rsp_b1 <= {4'h0, cmd_b1[3:0]};
                rsp_b3 <= reply_cnt_r + 8'h01;
                reply_cnt_r <= reply_cnt_r + 8'h01;
                if (!is_ct) begin
                    rsp_b2 <= ttsc_pkg::ST_BAD_CMD;
                end else if (!chan_ok) begin
                    rsp_b2 <= ttsc_pkg::ST_BAD_CHAN;
                end else if (!code_ok) begin
                    rsp_b2 <= ttsc_pkg::ST_BAD_TYPE;
                end else begin
                    rsp_b2 <= ttsc_pkg::ST_OK;
                end
            end
        end
    end

    // Unused bytes stay zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_b4 <= 8'h00;
            rsp_b5 <= 8'h00;
            rsp_b6 <= 8'h00;
            rsp_b7 <= 8'h00;
        end else begin
            rsp_b4 <= 8'h00;
            rsp_b5 <= 8'h00;
            rsp_b6 <= 8'h00;
            rsp_b7 <= 8'h00;
        end
    end

    // Head configuration and persistence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            head_cfg_valid <= 1'b0;
            head_cfg_chan <= 3'h0;
            head_cfg_type <= 8'h00;
            head_cfg_use_default <= 1'b0;
            nv_wr <= 1'b0;
            nv_chan <= 3'h0;
            nv_type <= 8'h00;
        end else begin
            head_cfg_valid <= accept;
            nv_wr <= accept;
            if (accept) begin
                head_cfg_chan <= chan;
                head_cfg_type <= code_nxt;
                head_cfg_use_default <= code_nxt == ttsc_pkg::TAG_DEFAULT_CODE;
                nv_chan <= chan;
                nv_type <= code_nxt;
            end
        end
    end

    a_rsp_code: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_valid |=> rsp_valid && rsp_b0 == ttsc_pkg::CMD_CHANGE_TAG)
        else $error("response code wrong");
    a_echo_chan: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_valid |=> rsp_b1 == {4'h0, $past(cmd_b1[3:0])})
        else $error("channel echo wrong");
    a_reply_count: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_valid ##1 rsp_valid |-> rsp_b3 == $past(reply_cnt_r) + 8'h01)
        else $error("reply count wrong");
    a_zero_tail: assert property (@(posedge clk_sys) disable iff (rst)
        rsp_valid |-> (rsp_b4 | rsp_b5 | rsp_b6 | rsp_b7) == 8'h00)
        else $error("unused bytes nonzero");
    a_head_cfg: assert property (@(posedge clk_sys) disable iff (rst)
        accept |=> head_cfg_valid && head_cfg_type == $past(code_nxt))
        else $error("head not configured");
    a_nv_store: assert property (@(posedge clk_sys) disable iff (rst)
        head_cfg_valid == nv_wr)
        else $error("store not written");
    a_bad_type: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_valid && is_ct && chan_ok && !code_ok |=> !head_cfg_valid && rsp_b2 == ttsc_pkg::ST_BAD_TYPE)
        else $error("bad type accepted");
    a_default_use: assert property (@(posedge clk_sys) disable iff (rst)
        head_cfg_valid |-> head_cfg_use_default == (head_cfg_type == ttsc_pkg::TAG_DEFAULT_CODE))
        else $error("default flag wrong");
    a_factory: assert property (@(posedge clk_sys) disable iff (rst)
        factory_restore |=> tag_r[0] == ttsc_pkg::TAG_DEFAULT_CODE)
        else $error("restore failed");
    a_block8: assert property (@(posedge clk_sys) disable iff (rst)
        tag_r[0] == ttsc_pkg::TAG_BLOCK8_CODE |=> chan_block8[0])
        else $error("block size wrong");

    // Take sequences shared by the status checks
    sequence s_take_ok;
        accept;
    endsequence
    sequence s_take_bad_cmd;
        cmd_valid && !is_ct;
    endsequence
    sequence s_take_bad_chan;
        cmd_valid && is_ct && !chan_ok;
    endsequence

    // Status per take; refused frames still answer, but touch nothing
    a_ok_status: assert property (@(posedge clk_sys) disable iff (rst)
        s_take_ok |=> rsp_b2 == ttsc_pkg::ST_OK && head_cfg_valid)
        else $error("accepted status wrong");

    a_bad_cmd: assert property (@(posedge clk_sys) disable iff (rst)
        s_take_bad_cmd |=> rsp_b2 == ttsc_pkg::ST_BAD_CMD && !nv_wr)
        else $error("foreign command status wrong");

    a_bad_chan: assert property (@(posedge clk_sys) disable iff (rst)
        s_take_bad_chan |=> rsp_b2 == ttsc_pkg::ST_BAD_CHAN && !head_cfg_valid)
        else $error("bad channel status wrong");

    // Accepted frames land channel and type together
    a_cfg_chan: assert property (@(posedge clk_sys) disable iff (rst)
        s_take_ok |=> head_cfg_chan == $past(chan) && nv_chan == $past(chan))
        else $error("configured channel wrong");

    a_nv_type: assert property (@(posedge clk_sys) disable iff (rst)
        s_take_ok |=> nv_type == $past(code_nxt))
        else $error("stored type wrong");

    // Pulses drop one cycle after the command or accept drops; data bytes hold
    a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        !cmd_valid |=> !rsp_valid)
        else $error("response without command");

    a_cfg_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        !accept |=> !head_cfg_valid)
        else $error("head configured without accept");

    a_reply_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !cmd_valid |=> rsp_b3 == $past(rsp_b3))
        else $error("reply count moved while idle");

    // Reserved bits and toggle bit of the echo byte
    a_reserved_hi: assert property (@(posedge clk_sys) disable iff (rst)
        rsp_valid |-> rsp_b1[7:4] == 4'h0)
        else $error("reserved echo bits set");

    a_toggle_echo: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_valid |=> rsp_b1[0] == $past(cmd_b1[0]))
        else $error("toggle echo wrong");

endmodule : ttsc_change_tag

// File: hdl/ttsc_pkg.sv
package ttsc_pkg;
    // Frame layout and codes
    localparam int FRAME_BYTES = 8;
    localparam logic [7:0] CMD_CHANGE_TAG = 8'h04;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_NINE = 8'h39;
    localparam logic [7:0] TAG_DEFAULT_CODE = 8'h99;
    localparam logic [7:0] TAG_BLOCK8_CODE = 8'h33;
    localparam logic [2:0] CHAN_BYTE_MASK_HI = 3'h0;
    // Status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_BAD_TYPE = 8'h04;
    localparam logic [7:0] ST_BAD_CHAN = 8'h05;
    localparam logic [7:0] ST_BAD_CMD = 8'h07;
    // Block sizes in bytes, then reply count reset value
    localparam logic [3:0] BLOCK_BYTES_STD = 4'h4;
    localparam logic [3:0] BLOCK_BYTES_WIDE = 4'h8;
    localparam logic [7:0] RESET_REPLY_COUNT = 8'h00;
endpackage : ttsc_pkg

// File: tb/ttsc_change_tag_tb.sv
module ttsc_change_tag_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, factory_restore, cmd_valid, rsp_valid, head_cfg_valid, head_cfg_use_default, nv_wr;
    logic [7:0] cmd_b0, cmd_b1, cmd_b2, cmd_b3, rsp_b0, rsp_b1, rsp_b2, rsp_b3, rsp_b4, rsp_b5, rsp_b6, rsp_b7;
    logic [7:0] head_cfg_type, nv_type, cnt;
    logic [2:0] head_cfg_chan, nv_chan;
    logic [3:0] chan_block8, chan_uid_4or7;
    int bad_count = 0;
    int total_checks = 0;
    ttsc_master_model i_ttsc_master_model (.clk_sys, .cmd_valid, .cmd_b0, .cmd_b1, .cmd_b2, .cmd_b3);
    ttsc_change_tag #(.CHANNELS(4)) i_ttsc_change_tag (.clk_sys, .rst, .cmd_valid, .cmd_b0, .cmd_b1, .cmd_b2,
        .cmd_b3, .factory_restore, .rsp_valid, .rsp_b0, .rsp_b1, .rsp_b2, .rsp_b3, .rsp_b4, .rsp_b5, .rsp_b6,
        .rsp_b7, .head_cfg_valid, .head_cfg_chan, .head_cfg_type, .head_cfg_use_default, .nv_wr, .nv_chan,
        .nv_type, .chan_block8, .chan_uid_4or7);
    task automatic chk(input string what, input logic [7:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Sends one frame and judges the reply 1 ns after the take edge
    task automatic cmd(input logic [7:0] c, b1, ty, st);
        i_ttsc_master_model.send(c, b1, {4'h3, ty[7:4]}, {4'h3, ty[3:0]});
        #1;
        cnt = cnt + 8'h01;
        chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
        chk("rsp_b0", ttsc_pkg::CMD_CHANGE_TAG, rsp_b0);
        chk("rsp_b1", b1, rsp_b1);
        chk("rsp_b2", st, rsp_b2);
        chk("rsp_b3", cnt, rsp_b3);
        chk("rsp_tail", 8'h00, rsp_b4 | rsp_b5 | rsp_b6 | rsp_b7);
        chk("head_valid", {7'h0, st == ttsc_pkg::ST_OK}, {7'h0, head_cfg_valid});
        chk("nv_wr", {7'h0, st == ttsc_pkg::ST_OK}, {7'h0, nv_wr});
        if (st == ttsc_pkg::ST_OK) begin
            chk("head_chan", {5'h0, b1[3:1]}, {5'h0, head_cfg_chan});
            chk("head_type", ty, head_cfg_type);
            chk("nv_chan", {5'h0, b1[3:1]}, {5'h0, nv_chan});
            chk("nv_type", ty, nv_type);
            chk("use_default", {7'h0, ty == 8'h99}, {7'h0, head_cfg_use_default});
        end
    endtask : cmd
    task automatic test_codes;
        logic [7:0] codes[27] = '{8'h02, 8'h03, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h31, 8'h33,
            8'h34, 8'h35, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50, 8'h52, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h80,
            8'h99, 8'h99};
        foreach (codes[i]) cmd(8'h04, 8'h01, codes[i], ttsc_pkg::ST_OK);
        // Specific types fixed here rather than left on the default
        // Frame carries no block count, so the even-count duty stays with the master
        $display("test_codes done");
    endtask : test_codes
    task automatic test_refuse;
        cmd(8'h05, 8'h02, 8'h20, ttsc_pkg::ST_BAD_CMD);
        cmd(8'h04, 8'h09, 8'h20, ttsc_pkg::ST_BAD_CHAN);
        cmd(8'h04, 8'h02, 8'h98, ttsc_pkg::ST_BAD_TYPE);
        cmd(8'h04, 8'h02, 8'h1a, ttsc_pkg::ST_BAD_TYPE);
        $display("test_refuse done");
    endtask : test_refuse
    // Geometry flags follow two cycles after the accept
    task automatic test_geom;
        cmd(8'h04, 8'h01, 8'h33, ttsc_pkg::ST_OK);
        cmd(8'h04, 8'h04, 8'h42, ttsc_pkg::ST_OK);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("block8", 8'h01, {4'h0, chan_block8});
        chk("uid47", 8'h04, {4'h0, chan_uid_4or7});
        @(posedge clk_sys);
        factory_restore <= 1'b1;
        @(posedge clk_sys);
        factory_restore <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("restored", 8'h00, {chan_block8, chan_uid_4or7});
        $display("test_geom done");
    endtask : test_geom
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        factory_restore = 1'b0;
        cnt = 8'h00;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("reset_flags", 8'h00, {chan_block8, chan_uid_4or7});
        test_codes();
        test_refuse();
        test_geom();
        complete_run();
    end
endmodule : ttsc_change_tag_tb

// File: tb/ttsc_master_model.sv
module ttsc_master_model (
    // Clock
    input wire logic clk_sys,
    // Command frame out
    output logic cmd_valid,
    output logic [7:0] cmd_b0,
    output logic [7:0] cmd_b1,
    output logic [7:0] cmd_b2,
    output logic [7:0] cmd_b3
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        {cmd_b0, cmd_b1, cmd_b2, cmd_b3} = 32'h0;
    end
    // Type goes as two ASCII digits, high one first
    task automatic send(input logic [7:0] c, b1, hi, lo);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        {cmd_b0, cmd_b1, cmd_b2, cmd_b3} <= {c, b1, hi, lo};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // Stale bytes inverted so a late sample cannot match
        {cmd_b0, cmd_b1, cmd_b2, cmd_b3} <= ~{c, b1, hi, lo};
    endtask : send
endmodule : ttsc_master_model
